//--- tb_top.sv
/*
 Self-checking bench for wmr_regs over APB plus sample strobes.
 Assumes the checker file is compiled with it.
*/
`timescale 1ns/1ns
module tb_top;
   // Arbitrary identity values
   localparam logic [4:0] PT = 5'h0a;
   localparam logic [2:0] RV = 3'h3;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, tex = 0, ame = 0, pme = 0;
   logic asv = 0, psv = 0, ars = 0, ainc = 0, pready, pslverr, ams, pms, irq, err;
   logic [7:0] paddr = 8'h00, asmp = 8'h00, psmp = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0] pstrb = 4'hf, athr = 4'h0;
   logic [1:0] awgt = 2'h0;
   int n_fail = 0, checked = 0;
   wmr_regs #(.PART_TYPE_CODE(PT), .SILICON_REVISION_CODE(RV)) u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .timer_expiry(tex), .amplitude_meas_enable(ame), .phase_meas_enable(pme),
      .amplitude_meas_start(ams), .phase_meas_start(pms), .amplitude_sample_valid(asv),
      .amplitude_sample(asmp), .phase_sample_valid(psv), .phase_sample(psmp),
      .amplitude_reference_select(ars), .amplitude_delta_threshold(athr),
      .amplitude_include_trigger_sample(ainc), .amplitude_average_weight(awgt), .irq(irq));
   initial
   begin
      forever #5 pclk = ~pclk;
   end
   ////////////////////////////////////////////////////////////////////////////
   task test_done;
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : test_done
   task chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e)
      begin
         n_fail++;
         $display("[ERR] t=%0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   // Entered just after a rising edge; request held until pready is seen
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask : apb
   task rc(input logic [7:0] a, input logic [31:0] e);
      apb(0, a, 32'h0);
      chk(rd, e);
   endtask : rc
   // irq is settled two edges after the strobe edge
   task samp(input logic ph, input logic [7:0] v);
      psmp <= v;
      asmp <= v;
      psv <= ph;
      asv <= !ph;
      @(posedge pclk);
      psv <= 0;
      asv <= 0;
      repeat (2) @(posedge pclk);
   endtask : samp
   ////////////////////////////////////////////////////////////////////////////
   task t_reset;
      logic [7:0] al[9];
      al = '{8'hd0, 8'hd4, 8'hd8, 8'hdc, 8'he0, 8'he4, 8'he8, 8'hf0, 8'hf4};
      foreach (al[i]) rc(al[i], 32'h0);
      rc(8'hfc, {24'h0, PT, RV});
      chk({31'h0, irq}, 32'h0);
      $display("t_reset done");
   endtask : t_reset
   task t_rw;
      apb(1, 8'hd0, 32'ha5);
      rc(8'hd0, 32'ha5);
      apb(1, 8'he0, 32'h5a);
      rc(8'he0, 32'h5a);
      apb(1, 8'hd4, 32'hff);
      rc(8'hd4, 32'h0);
      apb(1, 8'he4, 32'hff);
      rc(8'he4, 32'h0);
      apb(1, 8'hfc, 32'h0);
      rc(8'hfc, {24'h0, PT, RV});
      apb(1, 8'hd1, 32'h33);
      chk({31'h0, err}, 32'h1);
      rc(8'h00, 32'h0);
      chk({31'h0, err}, 32'h1);
      rc(8'hd0, 32'ha5);
      pstrb <= 4'he;
      apb(1, 8'hd0, 32'h11);
      pstrb <= 4'hf;
      rc(8'hd0, 32'ha5);
      $display("t_rw done");
   endtask : t_rw
   task t_phase;
      apb(1, 8'hf4, 32'h3);
      apb(1, 8'he0, 32'h50);
      apb(1, 8'hdc, 32'h40);
      rc(8'hdc, 32'h40);
      samp(1, 8'h54);
      chk({31'h0, irq}, 32'h0);
      rc(8'he8, 32'h54);
      rc(8'he4, 32'h15);
      samp(1, 8'h60);
      chk({31'h0, irq}, 32'h1);
      rc(8'he4, 32'h15);
      rc(8'hf0, 32'h2);
      chk({31'h0, irq}, 32'h0);
      $display("t_phase done");
   endtask : t_phase
   task t_avg;
      apb(1, 8'hdc, 32'hfb);
      samp(1, 8'h1d);
      chk({31'h0, irq}, 32'h0);
      rc(8'he4, 32'h16);
      samp(1, 8'h40);
      chk({31'h0, irq}, 32'h1);
      rc(8'he4, 32'h1b);
      rc(8'hf0, 32'h2);
      $display("t_avg done");
   endtask : t_avg
   task t_amp;
      athr <= 4'h2;
      apb(1, 8'hd0, 32'h10);
      samp(0, 8'h0f);
      chk({31'h0, irq}, 32'h0);
      rc(8'hd4, 32'h3);
      samp(0, 8'h13);
      chk({31'h0, irq}, 32'h1);
      rc(8'hd8, 32'h13);
      rc(8'hd4, 32'h3);
      rc(8'hf0, 32'h1);
      apb(1, 8'hf4, 32'h2);
      rc(8'hf4, 32'h2);
      ars <= 1;
      samp(0, 8'h11);
      chk({31'h0, irq}, 32'h0);
      rc(8'hf0, 32'h1);
      $display("t_amp done");
   endtask : t_amp
   task t_timer;
      for (int i = 0; i < 2; i++)
      begin
         pme <= (i == 0);
         ame <= (i == 1);
         tex <= 1;
         @(posedge pclk);
         tex <= 0;
         @(posedge pclk);
         chk({30'h0, pms, ams}, (i == 0) ? 32'h2 : 32'h1);
      end
      $display("t_timer done");
   endtask : t_timer
   initial
   begin
      #20000;
      n_fail++;
      test_done;
   end
   initial
   begin
      repeat (10) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      t_reset;
      t_rw;
      t_phase;
      t_avg;
      t_amp;
      t_timer;
      test_done;
   end
endmodule : tb_top

//--- wmr_pkg.sv
/*
 Package for the wake-up measurement register bank: register indices,
 field positions, reset values and averaging weight codes.
 Assumes nothing of its surroundings; imported by wmr_regs.sv.
*/
package wmr_pkg;
   // Register indices; byte address is four times the index
   localparam logic [5:0] WMR_IDX_AMP_REF = 6'h34;
   localparam logic [5:0] WMR_IDX_AMP_AVG = 6'h35;
   localparam logic [5:0] WMR_IDX_AMP_RES = 6'h36;
   localparam logic [5:0] WMR_IDX_PH_CFG = 6'h37;
   localparam logic [5:0] WMR_IDX_PH_REF = 6'h38;
   localparam logic [5:0] WMR_IDX_PH_AVG = 6'h39;
   localparam logic [5:0] WMR_IDX_PH_RES = 6'h3a;
   localparam logic [5:0] WMR_IDX_IRQ_STAT = 6'h3c;
   localparam logic [5:0] WMR_IDX_IRQ_MASK = 6'h3d;
   localparam logic [5:0] WMR_IDX_ID = 6'h3f;
   localparam int WMR_ADDR_W = 8;
   localparam int WMR_IDX_LSB = 2;
   localparam logic [1:0] WMR_WORD_ALIGN = 2'h0;

   // Phase configuration fields
   localparam int WMR_PH_THR_MSB = 7;
   localparam int WMR_PH_THR_LSB = 4;
   localparam int WMR_PH_INCL_BIT = 3;
   localparam int WMR_PH_WGT_MSB = 2;
   localparam int WMR_PH_WGT_LSB = 1;
   localparam int WMR_PH_SEL_BIT = 0;

   // Interrupt status / mask bits
   localparam int WMR_IRQ_W = 2;
   localparam int WMR_IRQ_AMP_BIT = 0;
   localparam int WMR_IRQ_PH_BIT = 1;

   localparam logic [7:0] WMR_REG_RESET = 8'h00;
   localparam logic [WMR_IRQ_W-1:0] WMR_IRQ_RESET = 2'h0;

   // Weight codes: 4, 8, 16, 32 as right shifts
   localparam logic [1:0] WMR_WGT_4 = 2'h0;
   localparam logic [1:0] WMR_WGT_8 = 2'h1;
   localparam logic [1:0] WMR_WGT_16 = 2'h2;
   localparam logic [1:0] WMR_WGT_32 = 2'h3;
   localparam int WMR_SHIFT_4 = 2;
   localparam int WMR_SHIFT_8 = 3;
   localparam int WMR_SHIFT_16 = 4;
   localparam int WMR_SHIFT_32 = 5;
endpackage : wmr_pkg

//--- wmr_regs.sv
/*
 Wake-up measurement register bank: APB slave, amplitude and phase
 averaging/compare channels, sticky interrupt status with mask.
 Holds one channel module used twice. Each channel keeps the latest
 sample and a running average with a selectable weight. It raises a
 one-cycle wake strobe when a sample strays beyond its threshold.
 Register map, one byte in the low bits of each aligned word:
   amplitude reference, average and result, phase configuration,
   phase reference, average and result, interrupt status and mask,
   identity.
 Unmapped or misaligned accesses answer with pslverr and read zero.
 Assumes measurement samples and timer expiry arrive on pclk as
 one-cycle strobes from logic in the same clock domain.
 Assumes an APB master that gives a setup cycle before every access.
 The bank answers with zero wait states and captures read data in
 the setup cycle, so a status read clears only what it returned.
 Assumes the amplitude configuration comes from a register kept
 outside this bank, as plain level inputs.
 Assumes the timer and the measurement circuits sit outside the bank.
*/
// What this block does
// - Phase config bits 7:4 give the phase difference threshold for wake interrupt.
// - Phase config bit 3 low excludes the triggering sample from averaging.
// - Phase config bits 2:1 select newest-sample weight: 00 gives 4, 01 gives 8.
// - Phase config bit 0 picks stored reference (0) or running average (1).
// - Amplitude reference register, 8-bit read/write at 34h, resets to zero.
// - Amplitude running average shown read-only at 35h, resets to zero.
// - Latest amplitude result shown read-only at 36h, resets to zero.
// - Phase reference register, 8-bit read/write at 38h, resets to zero.
// - Phase running average shown read-only at 39h, resets to zero.
// - Latest phase result shown at 3Ah, resets to zero.
// - Identity at 3Fh: five-bit part type above three-bit revision, fixed.
// - Amplitude compare uses stored reference when select is 0, else average.
// - Phase enabled: measure on each timer expiry, interrupt if difference exceeds threshold.
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
module wmr_channel
   import wmr_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic sample_valid,
   input wire logic [7:0] sample,
   input wire logic [7:0] stored_ref,
   input wire logic ref_select,
   input wire logic [3:0] threshold,
   input wire logic include_trigger,
   input wire logic [1:0] weight,
   output logic [7:0] latest,
   output logic [7:0] average,
   output logic wake
);
   logic [7:0] next_latest;
   logic [7:0] next_average;
   logic next_wake;
   logic [7:0] cmp_ref;
   logic [8:0] diff;
   logic [8:0] mag;
   logic exceed;
   logic signed [8:0] delta;
   logic signed [8:0] step;

   // Compare against the chosen reference; the step floors toward minus infinity
   always_comb
   begin
      cmp_ref = ref_select ? average : stored_ref;
      diff = {1'b0, sample} - {1'b0, cmp_ref};
      mag = diff[8] ? 9'(-diff) : diff;
      exceed = mag > {5'h00, threshold};
      delta = $signed({1'b0, sample}) - $signed({1'b0, average});
      unique case (weight)
         WMR_WGT_4: step = delta >>> WMR_SHIFT_4;
         WMR_WGT_8: step = delta >>> WMR_SHIFT_8;
         WMR_WGT_16: step = delta >>> WMR_SHIFT_16;
         WMR_WGT_32: step = delta >>> WMR_SHIFT_32;
      endcase
   end

   // Next result, average and wake strobe
   always_comb
   begin
      next_latest = latest;
      next_average = average;
      next_wake = 1'b0;
      if (sample_valid)
      begin
         next_latest = sample;
         next_wake = exceed;
         // Triggering sample kept out so an intruder does not drag the baseline
         if (!exceed || include_trigger)
         begin
            next_average = average + step[7:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         latest <= WMR_REG_RESET;
         average <= WMR_REG_RESET;
         wake <= 1'b0;
      end
      else
      begin
         latest <= next_latest;
         average <= next_average;
         wake <= next_wake;
      end
   end
endmodule : wmr_channel

////////////////////////////////////////////////////////////////////////////////
module wmr_regs
   import wmr_pkg::*;
#(
   // Arbitrary neutral identity values
   parameter logic [4:0] PART_TYPE_CODE = 5'h11,
   parameter logic [2:0] SILICON_REVISION_CODE = 3'h5
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [WMR_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic timer_expiry,
   input wire logic amplitude_meas_enable,
   input wire logic phase_meas_enable,
   output logic amplitude_meas_start,
   output logic phase_meas_start,
   input wire logic amplitude_sample_valid,
   input wire logic [7:0] amplitude_sample,
   input wire logic phase_sample_valid,
   input wire logic [7:0] phase_sample,
   input wire logic amplitude_reference_select,
   input wire logic [3:0] amplitude_delta_threshold,
   input wire logic amplitude_include_trigger_sample,
   input wire logic [1:0] amplitude_average_weight,
   output logic irq
);
   // Registers seen by software
   logic [7:0] amplitude_reference;
   logic [7:0] phase_measure_config;
   logic [7:0] phase_reference;
   logic [WMR_IRQ_W-1:0] irq_status;
   logic [WMR_IRQ_W-1:0] irq_mask;
   logic rd_error;

   // Next values
   logic [7:0] next_amplitude_reference;
   logic [7:0] next_phase_measure_config;
   logic [7:0] next_phase_reference;
   logic [WMR_IRQ_W-1:0] next_irq_status;
   logic [WMR_IRQ_W-1:0] next_irq_mask;
   logic [31:0] next_prdata;
   logic next_rd_error;
   logic next_amplitude_meas_start;
   logic next_phase_meas_start;

   // Channel results
   logic [7:0] amplitude_latest_result;
   logic [7:0] amplitude_running_average;
   logic [7:0] phase_latest_result;
   logic [7:0] phase_running_average;
   logic amp_wake;
   logic phase_wake;

   // Bus decode
   logic [5:0] idx;
   logic aligned;
   logic setup;
   logic access;
   logic wr_en;
   logic status_read;
   logic [7:0] rd_byte;
   logic rd_hit;
   logic [WMR_IRQ_W-1:0] rd_clear;
   logic [WMR_IRQ_W-1:0] events;

   // Amplitude channel configuration arrives on plain input pins
   wmr_channel u_amplitude (
      .pclk(pclk),
      .presetn(presetn),
      .sample_valid(amplitude_sample_valid),
      .sample(amplitude_sample),
      .stored_ref(amplitude_reference),
      .ref_select(amplitude_reference_select),
      .threshold(amplitude_delta_threshold),
      .include_trigger(amplitude_include_trigger_sample),
      .weight(amplitude_average_weight),
      .latest(amplitude_latest_result),
      .average(amplitude_running_average),
      .wake(amp_wake)
   );

   // Phase channel fields come from the configuration register
   wmr_channel u_phase (
      .pclk(pclk),
      .presetn(presetn),
      .sample_valid(phase_sample_valid),
      .sample(phase_sample),
      .stored_ref(phase_reference),
      .ref_select(phase_measure_config[WMR_PH_SEL_BIT]),
      .threshold(phase_measure_config[WMR_PH_THR_MSB:WMR_PH_THR_LSB]),
      .include_trigger(phase_measure_config[WMR_PH_INCL_BIT]),
      .weight(phase_measure_config[WMR_PH_WGT_MSB:WMR_PH_WGT_LSB]),
      .latest(phase_latest_result),
      .average(phase_running_average),
      .wake(phase_wake)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode; zero wait states, so pready is constant high
   assign pready = 1'b1;
   // Error latched at setup, shown only in the access phase
   assign pslverr = access && rd_error;
   assign idx = paddr[WMR_ADDR_W-1:WMR_IDX_LSB];
   assign aligned = paddr[WMR_IDX_LSB-1:0] == WMR_WORD_ALIGN;
   assign setup = psel && !penable;
   assign access = psel && penable;
   assign wr_en = access && pwrite && pstrb[0] && !rd_error;
   assign status_read = access && !pwrite && !rd_error && idx == WMR_IDX_IRQ_STAT;
   // Level interrupt straight from the registers, no added latency
   assign irq = |(irq_status & irq_mask);

   always_comb
   begin
      rd_byte = 8'h00;
      rd_hit = aligned;
      unique case (idx)
         WMR_IDX_AMP_REF: rd_byte = amplitude_reference;
         WMR_IDX_AMP_AVG: rd_byte = amplitude_running_average;
         WMR_IDX_AMP_RES: rd_byte = amplitude_latest_result;
         WMR_IDX_PH_CFG: rd_byte = phase_measure_config;
         WMR_IDX_PH_REF: rd_byte = phase_reference;
         WMR_IDX_PH_AVG: rd_byte = phase_running_average;
         WMR_IDX_PH_RES: rd_byte = phase_latest_result;
         WMR_IDX_IRQ_STAT: rd_byte = {6'h00, irq_status};
         WMR_IDX_IRQ_MASK: rd_byte = {6'h00, irq_mask};
         WMR_IDX_ID: rd_byte = {PART_TYPE_CODE, SILICON_REVISION_CODE};
         default: rd_hit = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data is captured in the setup cycle so it comes from a flip-flop
   always_comb
   begin
      next_prdata = prdata;
      next_rd_error = rd_error;
      if (setup)
      begin
         next_prdata = (rd_hit && !pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
         next_rd_error = !rd_hit;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h00000000;
         rd_error <= 1'b0;
      end
      else
      begin
         prdata <= next_prdata;
         rd_error <= next_rd_error;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Writable configuration registers; writes to read-only indices fall through
   always_comb
   begin
      next_amplitude_reference = amplitude_reference;
      next_phase_measure_config = phase_measure_config;
      next_phase_reference = phase_reference;
      if (wr_en)
      begin
         unique case (idx)
            WMR_IDX_AMP_REF: next_amplitude_reference = pwdata[7:0];
            WMR_IDX_PH_CFG: next_phase_measure_config = pwdata[7:0];
            WMR_IDX_PH_REF: next_phase_reference = pwdata[7:0];
            default: next_phase_reference = phase_reference;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         amplitude_reference <= WMR_REG_RESET;
         phase_measure_config <= WMR_REG_RESET;
         phase_reference <= WMR_REG_RESET;
      end
      else
      begin
         amplitude_reference <= next_amplitude_reference;
         phase_measure_config <= next_phase_measure_config;
         phase_reference <= next_phase_reference;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sticky interrupt status and its mask
   always_comb
   begin
      next_irq_mask = irq_mask;
      if (wr_en && idx == WMR_IDX_IRQ_MASK)
      begin
         next_irq_mask = pwdata[WMR_IRQ_W-1:0];
      end
      // Clear only bits the reader saw; a new event still wins over the clear
      rd_clear = WMR_IRQ_RESET;
      if (status_read)
      begin
         rd_clear = prdata[WMR_IRQ_W-1:0];
      end
      events = WMR_IRQ_RESET;
      events[WMR_IRQ_AMP_BIT] = amp_wake;
      events[WMR_IRQ_PH_BIT] = phase_wake;
      next_irq_status = (irq_status & ~rd_clear) | events;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_status <= WMR_IRQ_RESET;
         irq_mask <= WMR_IRQ_RESET;
      end
      else
      begin
         irq_status <= next_irq_status;
         irq_mask <= next_irq_mask;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Measurement start strobes, one cycle after the timer expiry
   always_comb
   begin
      next_amplitude_meas_start = timer_expiry && amplitude_meas_enable;
      next_phase_meas_start = timer_expiry && phase_meas_enable;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         amplitude_meas_start <= 1'b0;
         phase_meas_start <= 1'b0;
      end
      else
      begin
         amplitude_meas_start <= next_amplitude_meas_start;
         phase_meas_start <= next_phase_meas_start;
      end
   end
endmodule : wmr_regs

//--- wmr_regs_chk.sv
/*
 Port checker for the wake-up measurement register bank.
 Assumes a single pclk domain; bound to every wmr_regs instance below.
*/
`timescale 1ns/1ns
module wmr_regs_chk
   import wmr_pkg::*;
#(
   parameter logic [4:0] PART_TYPE_CODE = 5'h11,
   parameter logic [2:0] SILICON_REVISION_CODE = 3'h5
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [WMR_ADDR_W-1:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic timer_expiry,
   input wire logic amplitude_meas_enable,
   input wire logic phase_meas_enable,
   input wire logic amplitude_meas_start,
   input wire logic phase_meas_start,
   input wire logic amplitude_sample_valid,
   input wire logic phase_sample_valid,
   input wire logic irq
);
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   wire acc = psel && penable;
   wire rd = acc && !pwrite;
   wire smp = amplitude_sample_valid || phase_sample_valid;
   wire good = paddr[1:0] == 2'h0 && paddr[7:2] inside {[6'h34:6'h3a], 6'h3c, 6'h3d, 6'h3f};
   ////////////////////////////////////////////////////////////////////////////
   zero_wait_a: assert property (acc |-> pready)
      else $error("access not completed");
   map_ok_a: assert property (acc && good |-> !pslverr)
      else $error("mapped access refused");
   map_err_a: assert property (rd && !good |-> pslverr && prdata == 32'h0)
      else $error("unmapped read not refused");
   upper_zero_a: assert property (rd |-> prdata[31:8] == 24'h0)
      else $error("read data upper bits set");
   id_value_a: assert property (rd && paddr == 8'hfc |-> prdata[7:0] == {PART_TYPE_CODE, SILICON_REVISION_CODE})
      else $error("identity value wrong");
   ph_start_a: assert property (timer_expiry && phase_meas_enable |=> phase_meas_start)
      else $error("phase start missing");
   ph_idle_a: assert property (!(timer_expiry && phase_meas_enable) |=> !phase_meas_start)
      else $error("phase start unexpected");
   am_start_a: assert property (timer_expiry && amplitude_meas_enable |=> amplitude_meas_start)
      else $error("amplitude start missing");
   irq_cause_a: assert property ($rose(irq) |-> $past(smp, 2) || $past(acc && pwrite))
      else $error("irq rose without cause");
   // Samples two cycles back may land after read data was captured
   irq_clear_a: assert property (rd && paddr == 8'hf0 && !smp && !$past(smp) && !$past(smp, 2) |=> !irq)
      else $error("irq stays after status read");
endmodule : wmr_regs_chk

bind wmr_regs wmr_regs_chk #(
   .PART_TYPE_CODE(PART_TYPE_CODE),
   .SILICON_REVISION_CODE(SILICON_REVISION_CODE)
) u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_expiry(timer_expiry),
   .amplitude_meas_enable(amplitude_meas_enable), .phase_meas_enable(phase_meas_enable),
   .amplitude_meas_start(amplitude_meas_start), .phase_meas_start(phase_meas_start),
   .amplitude_sample_valid(amplitude_sample_valid), .phase_sample_valid(phase_sample_valid), .irq(irq)
);
